/* File: include/iecs_map.svh */
// offsets, field positions, reset values and constants of the interrupt
// control and context shadow block; assumes word-aligned AHB-Lite access
`ifndef IECS_MAP_SVH
`define IECS_MAP_SVH

// register byte offsets (low address byte)
`define IECS_ADDR_INTCTL      8'h00
`define IECS_ADDR_PEN_ONE     8'h04
`define IECS_ADDR_PEN_TWO     8'h08
`define IECS_ADDR_STATE       8'h0C
// shadow bank, one byte per word, indices 0..7
`define IECS_ADDR_SHADOW_BASE 8'h40
`define IECS_ADDR_SHADOW_LAST 8'h5C

// core_interrupt_control fields
`define IECS_GIE_BIT          7
`define IECS_PERIPHERAL_IRQ_GATE_BIT         6
`define IECS_T0_EN_BIT        5
`define IECS_EDGE_EN_BIT      4
`define IECS_PCHG_EN_BIT      3
`define IECS_T0_FLAG_BIT      2
`define IECS_EDGE_FLAG_BIT    1
`define IECS_PCHG_FLAG_BIT    0

// reset values and implemented-bit masks
`define IECS_INTCTL_RESET     8'h00
`define IECS_PEN_ONE_RESET    8'h00
`define IECS_PEN_TWO_RESET    8'h00
`define IECS_PEN_TWO_MASK     8'h89

// interrupt vector and program counter width
`define IECS_PC_WIDTH         15
`define IECS_VECTOR           15'h0004

// shadow layout: working, status, bank, ptr0 lo/hi, ptr1 lo/hi, pc latch
`define IECS_SHADOW_DEPTH     8
`define IECS_SHADOW_MASK      64'h7FFF_FFFF_FF1F_E7FF

`endif

/* File: include/iecs_pkg.sv */
// types of the interrupt control and context shadow block
// assumes iecs_map.svh is on the include path
`include "iecs_map.svh"

package iecs_pkg;

  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_entry  = 2'b01,
    st_return = 2'b10
  } iecs_state_t;

  typedef struct packed {
    iecs_state_t                state;
    logic [7:0]                 intctl;
    logic [7:0]                 pen_one;
    logic [7:0]                 pen_two;
    logic [2:0]                 edge_sync;
    logic                       wr_pend;
    logic [7:0]                 wr_addr;
    logic                       hreadyout;
    logic                       hresp;
    logic [31:0]                hrdata;
    logic                       irq_request;
    logic                       flush_prefetch;
    logic                       stack_push;
    logic                       stack_pop;
    logic                       pc_load;
    logic                       context_restore;
    logic [`IECS_PC_WIDTH-1:0]  push_pc;
    logic [`IECS_PC_WIDTH-1:0]  pc_load_value;
  } iecs_ctrl_t;

  typedef struct packed {
    logic [`IECS_SHADOW_DEPTH-1:0][7:0] bytes;
  } iecs_shadow_t;

endpackage

/* File: core/iecs_context_shadow.sv */
// context shadow copies: captured on interrupt entry, software accessible
// assumes save and write strobes come from logic on ref_clk
`timescale 1ns/1ps
`include "iecs_map.svh"

module iecs_context_shadow (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        save,
  input  wire logic [7:0]  live_working,
  input  wire logic [7:0]  live_status,
  input  wire logic [4:0]  live_bank,
  input  wire logic [15:0] live_ptr0,
  input  wire logic [15:0] live_ptr1,
  input  wire logic [6:0]  live_pc_latch,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [7:0]  wr_data,
  output logic [63:0]      shadow_bytes
);
  import iecs_pkg::*;

  iecs_shadow_t q;
  iecs_shadow_t n;
  logic [63:0]  live_all;

  assign live_all = {1'b0, live_pc_latch, live_ptr1, live_ptr0,
                     3'b000, live_bank, live_status, live_working};

  always_comb begin
    n = q;
    if (wr_en) begin
      n.bytes[wr_idx] = wr_data;
    end
    if (save) begin
      n.bytes = live_all;
    end
    n.bytes = n.bytes & `IECS_SHADOW_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign shadow_bytes = q.bytes;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  save_working_a: assert property (
    save |=> q.bytes[0] == $past(live_working))
    else $error("working copy not captured on entry");
  save_status_a: assert property (
    save |=> q.bytes[1] == ($past(live_status) & 8'hE7))
    else $error("status copy wrong or holds timeout bits");
  sw_write_a: assert property (
    wr_en && !save |=> q.bytes[$past(wr_idx)] ==
      ($past(wr_data) & 8'hFF &
       8'(`IECS_SHADOW_MASK >> (6'($past(wr_idx)) * 6'd8))))
    else $error("software shadow write lost");
  sw_write_c: cover property (wr_en ##1 save);

endmodule // iecs_context_shadow

/* File: core/iecs_irq_ctrl.sv */
// interrupt gating, enable registers, entry/return sequencing with shadows
// assumes AHB-Lite single word transfers; core strobes on ref_clk
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "iecs_map.svh"

module iecs_irq_ctrl #(
  parameter int HADDR_WIDTH = 32
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [HADDR_WIDTH-1:0] haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // interrupt sources
  input  wire logic                   timer_zero_overflow,
  input  wire logic                   edge_pin,
  input  wire logic                   edge_rising_select,
  input  wire logic [7:0]             port_b_change_flags,
  input  wire logic [7:0]             periph_flags_one,
  input  wire logic [7:0]             periph_flags_two,
  // core sequencer
  input  wire logic                   core_irq_accept,
  input  wire logic                   core_return_exec,
  input  wire logic [14:0]            core_pc,
  input  wire logic [7:0]             live_working,
  input  wire logic [7:0]             live_status,
  input  wire logic [4:0]             live_bank,
  input  wire logic [15:0]            live_ptr0,
  input  wire logic [15:0]            live_ptr1,
  input  wire logic [6:0]             live_pc_latch,
  output logic                        irq_request,
  output logic                        flush_prefetch,
  output logic                        stack_push,
  output logic [14:0]                 push_pc,
  output logic                        stack_pop,
  output logic                        pc_load,
  output logic [14:0]                 pc_load_value,
  output logic                        context_restore,
  output logic [7:0]                  restore_working,
  output logic [7:0]                  restore_status,
  output logic [4:0]                  restore_bank,
  output logic [15:0]                 restore_ptr0,
  output logic [15:0]                 restore_ptr1,
  output logic [6:0]                  restore_pc_latch
);
  import iecs_pkg::*;

  if (HADDR_WIDTH < 8) begin : g_bad_width
    $error("haddr must be at least 8 bits wide");
  end

  iecs_ctrl_t  q;
  iecs_ctrl_t  n;
  logic [63:0] shadow_bytes;
  logic        shadow_save;
  logic        shadow_wr;
  logic [7:0]  addr_lo;
  logic        addr_phase;
  logic        edge_event;
  logic        pchg_summary;
  logic [2:0]  core_hits;
  logic        periph_hit;

  function automatic logic is_shadow(input logic [7:0] a);
    return a >= `IECS_ADDR_SHADOW_BASE && a <= `IECS_ADDR_SHADOW_LAST;
  endfunction

  function automatic logic [2:0] shadow_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - `IECS_ADDR_SHADOW_BASE;
    return off[4:2];
  endfunction

  assign addr_lo    = haddr[7:0];
  assign addr_phase = hsel && htrans[1] && hready;

  assign pchg_summary = |port_b_change_flags;

  // capture only when an entry is taken
  assign shadow_save = (q.state == st_idle) && core_irq_accept &&
                       q.irq_request;
  // software writes into the shadow bank
  assign shadow_wr   = q.wr_pend && is_shadow(q.wr_addr);

  // edge detect on the synchronised pin
  assign edge_event = edge_rising_select ?
                      (q.edge_sync[1] && !q.edge_sync[2]) :
                      (!q.edge_sync[1] && q.edge_sync[2]);

  always_comb begin
    n = q;
    n.flush_prefetch  = 1'b0;
    n.stack_push      = 1'b0;
    n.stack_pop       = 1'b0;
    n.pc_load         = 1'b0;
    n.context_restore = 1'b0;
    n.hreadyout       = 1'b1;
    n.hresp           = 1'b0;
    n.edge_sync       = {q.edge_sync[1:0], edge_pin};

    // address phase: latch writes, prepare read data
    n.wr_pend = addr_phase && hwrite;
    if (addr_phase && hwrite) begin
      n.wr_addr = addr_lo;
    end
    if (addr_phase && !hwrite) begin
      n.hrdata = 32'h0000_0000;
      if (is_shadow(addr_lo)) begin
        n.hrdata[7:0] = shadow_bytes[8*shadow_idx(addr_lo) +: 8];
      end else begin
        unique case (addr_lo)
          `IECS_ADDR_INTCTL: begin
            n.hrdata[7:0] = {q.intctl[7:1], pchg_summary};
          end
          `IECS_ADDR_PEN_ONE: n.hrdata[7:0] = q.pen_one;
          `IECS_ADDR_PEN_TWO: n.hrdata[7:0] = q.pen_two;
          `IECS_ADDR_STATE: begin
            n.hrdata[3:0] = {q.irq_request, 1'b0, q.state};
          end
          default: n.hrdata = 32'h0000_0000;
        endcase
      end
    end

    // data phase: commit the write
    if (q.wr_pend) begin
      unique case (q.wr_addr)
        `IECS_ADDR_INTCTL: begin
          // bits 7..1 writable, bit 0 read-only
          n.intctl[7:1] = hwdata[7:1];
        end
        `IECS_ADDR_PEN_ONE: begin
          n.pen_one = hwdata[7:0];
        end
        `IECS_ADDR_PEN_TWO: begin
          n.pen_two = hwdata[7:0] & `IECS_PEN_TWO_MASK;
        end
        default: n.pen_two = n.pen_two;
      endcase
    end

    // flags set whatever the enables; set beats a clear
    if (timer_zero_overflow) begin
      n.intctl[`IECS_T0_FLAG_BIT] = 1'b1;
    end
    if (edge_event) begin
      n.intctl[`IECS_EDGE_FLAG_BIT] = 1'b1;
    end
    n.intctl[`IECS_PCHG_FLAG_BIT] = 1'b0;

    unique case (q.state)
      st_idle: begin
        if (core_irq_accept && q.irq_request) begin
          // flush, clear gate, push return address
          n.flush_prefetch = 1'b1;
          n.stack_push     = 1'b1;
          n.push_pc        = core_pc;
          n.intctl[`IECS_GIE_BIT] = 1'b0;
          n.state          = st_entry;
        end else if (core_return_exec) begin
          // pop, restore context, reopen global gate
          n.stack_pop       = 1'b1;
          n.context_restore = 1'b1;
          n.intctl[`IECS_GIE_BIT] = 1'b1;
          n.state           = st_return;
        end
      end
      st_entry: begin
        n.pc_load       = 1'b1;
        n.pc_load_value = `IECS_VECTOR;
        n.state         = st_idle;
      end
      st_return: begin
        n.state = st_idle;
      end
      default: n.state = st_idle;
    endcase

    // request from gated flag and enable pairs
    core_hits = n.intctl[5:3] & {n.intctl[`IECS_T0_FLAG_BIT],
                                 n.intctl[`IECS_EDGE_FLAG_BIT],
                                 pchg_summary};
    // peripheral sources need the peripheral gate
    periph_hit = n.intctl[`IECS_PERIPHERAL_IRQ_GATE_BIT] &&
                 |((n.pen_one & periph_flags_one) |
                   (n.pen_two & periph_flags_two));
    // global gate holds pending sources back
    n.irq_request = n.intctl[`IECS_GIE_BIT] &&
                    (|core_hits || periph_hit) &&
                    (n.state == st_idle);
  end

  // every reset clears enables and gates
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
      // pin history keeps running so an idle-high pin gives no false edge
      q.edge_sync <= n.edge_sync;
    end else begin
      q <= n;
    end
  end

  iecs_context_shadow u_shadow (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .save          (shadow_save),
    .live_working  (live_working),
    .live_status   (live_status),
    .live_bank     (live_bank),
    .live_ptr0     (live_ptr0),
    .live_ptr1     (live_ptr1),
    .live_pc_latch (live_pc_latch),
    .wr_en         (shadow_wr),
    .wr_idx        (shadow_idx(q.wr_addr)),
    .wr_data       (hwdata[7:0]),
    .shadow_bytes  (shadow_bytes)
  );

  assign hreadyout       = q.hreadyout;
  assign hresp           = q.hresp;
  assign hrdata          = q.hrdata;
  assign irq_request     = q.irq_request;
  assign flush_prefetch  = q.flush_prefetch;
  assign stack_push      = q.stack_push;
  assign push_pc         = q.push_pc;
  assign stack_pop       = q.stack_pop;
  assign pc_load         = q.pc_load;
  assign pc_load_value   = q.pc_load_value;
  assign context_restore = q.context_restore;
  // restore values come straight from the shadow copies
  assign restore_working  = shadow_bytes[7:0];
  assign restore_status   = shadow_bytes[15:8];
  assign restore_bank     = shadow_bytes[20:16];
  assign restore_ptr0     = shadow_bytes[39:24];
  assign restore_ptr1     = shadow_bytes[55:40];
  assign restore_pc_latch = shadow_bytes[62:56];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  push_then_vector_a: assert property (
    stack_push |=> pc_load && !stack_push)
    else $error("vector load did not follow the push");
  entry_clears_gie_a: assert property (
    stack_push |-> flush_prefetch && !q.intctl[`IECS_GIE_BIT])
    else $error("entry without flush or with gate open");
  vector_value_a: assert property (
    pc_load |-> pc_load_value == `IECS_VECTOR)
    else $error("wrong interrupt vector");
  return_seq_a: assert property (
    core_return_exec && q.state == st_idle && !shadow_save |=>
      stack_pop && context_restore && q.intctl[`IECS_GIE_BIT])
    else $error("return did not pop, restore and reopen gate");
  timer_flag_a: assert property (
    timer_zero_overflow |=> q.intctl[`IECS_T0_FLAG_BIT])
    else $error("timer overflow flag not set");
  edge_flag_a: assert property (
    edge_rising_select && $rose(q.edge_sync[1]) &&
      $stable(edge_rising_select) |=> q.intctl[`IECS_EDGE_FLAG_BIT])
    else $error("edge pin flag not set");
  gie_blocks_a: assert property (
    !q.intctl[`IECS_GIE_BIT] |-> !irq_request)
    else $error("request with global gate closed");
  pending_served_a: assert property (
    q.intctl[7] && q.intctl[5] && q.intctl[2] && q.state == st_idle
      |-> irq_request)
    else $error("pending timer interrupt not requested");
  periph_gate_a: assert property (
    !q.intctl[`IECS_PERIPHERAL_IRQ_GATE_BIT] && q.intctl[5:3] == 3'b000 |-> !irq_request)
    else $error("peripheral source passed a closed gate");
  reset_clear_a: assert property (
    $past(reset) |-> q.intctl == 8'h00 && q.pen_one == 8'h00 &&
      q.pen_two == 8'h00 && !irq_request)
    else $error("interrupts not disabled after reset");
  edge_fall_a: assert property (
    !edge_rising_select && $fell(q.edge_sync[1]) |=>
      q.intctl[`IECS_EDGE_FLAG_BIT])
    else $error("falling edge did not set the pin flag");
  summary_read_a: assert property (
    addr_phase && !hwrite && addr_lo == `IECS_ADDR_INTCTL |=>
      hrdata[`IECS_PCHG_FLAG_BIT] == $past(pchg_summary))
    else $error("summary bit not shown on read");
  gie_write_a: assert property (
    q.wr_pend && q.wr_addr == `IECS_ADDR_INTCTL && !core_irq_accept &&
      !core_return_exec |=> q.intctl[7:3] == $past(hwdata[7:3]))
    else $error("control write not taken");
  pen_one_wr_a: assert property (
    q.wr_pend && q.wr_addr == `IECS_ADDR_PEN_ONE |=>
      q.pen_one == $past(hwdata[7:0]))
    else $error("enable one write not taken");
  pen_two_wr_a: assert property (
    q.wr_pend && q.wr_addr == `IECS_ADDR_PEN_TWO |=>
      q.pen_two == ($past(hwdata[7:0]) & `IECS_PEN_TWO_MASK))
    else $error("enable two write wrong or unused bits set");
  flush_pulse_a: assert property (
    flush_prefetch |=> !flush_prefetch)
    else $error("flush held longer than one cycle");
  push_drops_req_a: assert property (
    stack_push |-> !irq_request)
    else $error("request still raised after entry");

  entry_c: cover property (irq_request ##1 stack_push ##1 pc_load);
  return_c: cover property (stack_pop ##[1:20] irq_request);
  held_c: cover property (!q.intctl[7] && q.intctl[2] ##1 q.intctl[7]);
  shadow_wr_c: cover property (shadow_wr ##[1:20] context_restore);

endmodule // iecs_irq_ctrl

/* File: testbench/iecs_core_model.sv */
// core sequencer model: takes interrupts and runs the return sequence
// assumes the bench drives arm, ret and lag just after rising edges
`timescale 1ns/1ps

module iecs_core_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        irq_request,
  input  wire logic        arm,
  input  wire logic        ret,
  input  wire logic [3:0]  lag,
  output logic             core_irq_accept,
  output logic             core_return_exec,
  output logic [14:0]      core_pc,
  output logic [7:0]       live_working,
  output logic [7:0]       live_status,
  output logic [4:0]       live_bank,
  output logic [15:0]      live_ptr0,
  output logic [15:0]      live_ptr1,
  output logic [6:0]       live_pc_latch
);
  logic [3:0] cnt;
  logic       done_a;
  logic       done_r;

  initial begin
    {core_irq_accept, core_return_exec, done_a, done_r} = 4'h0;
    cnt = 4'h0;
    {core_pc, live_working, live_status, live_bank, live_ptr0, live_ptr1,
     live_pc_latch} = 75'h0;
  end

  always @(posedge ref_clk) begin
    // live context changes every cycle so a late capture shows up
    {core_pc, live_working, live_status, live_bank, live_ptr0, live_ptr1,
     live_pc_latch} <= 75'({$urandom, $urandom, $urandom});
    core_irq_accept  <= 1'b0;
    core_return_exec <= 1'b0;
    if (reset || !arm) begin
      done_a <= 1'b0;
      cnt    <= 4'h0;
    end else if (irq_request && !done_a && !core_irq_accept) begin
      // one acceptance per arming, after lag cycles of waiting
      if (cnt == lag) begin
        core_irq_accept <= 1'b1;
        done_a          <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
    if (reset || !ret) begin
      done_r <= 1'b0;
    end else if (!done_r) begin
      core_return_exec <= 1'b1;
      done_r           <= 1'b1;
    end
  end
endmodule // iecs_core_model

/* File: testbench/iecs_irq_ctrl_tb.sv */
// self-checking bench of the interrupt control and context shadow block
// assumes the core model and the design files are compiled beforehand
`timescale 1ns/1ps
`include "iecs_map.svh"

module iecs_irq_ctrl_tb;
  import iecs_pkg::*;
  logic        ref_clk, reset, hsel, hwrite, edge_pin, edge_sel, t0_ovf;
  logic        arm, ret, hreadyout, hresp, irq_request, flush, push;
  logic        pop, pcld, restore, acc, rex, aq1, aq2, rq1;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  lag;
  logic [7:0]  pb, pf1, pf2, lw, ls, rw, rs, w, p1, p2, e, cap[8];
  logic [4:0]  lb, rb;
  logic [15:0] lp0, lp1, rp0, rp1;
  logic [6:0]  lpl, rpl;
  logic [14:0] push_pc, pcv, core_pc, pc_q[$];
  int          n_fail, n_compared, n_ent, n_ret, k, i;

  iecs_irq_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer_zero_overflow(t0_ovf),
    .edge_pin(edge_pin), .edge_rising_select(edge_sel),
    .port_b_change_flags(pb), .periph_flags_one(pf1),
    .periph_flags_two(pf2), .core_irq_accept(acc),
    .core_return_exec(rex), .core_pc(core_pc), .live_working(lw),
    .live_status(ls), .live_bank(lb), .live_ptr0(lp0), .live_ptr1(lp1),
    .live_pc_latch(lpl), .irq_request(irq_request),
    .flush_prefetch(flush), .stack_push(push), .push_pc(push_pc),
    .stack_pop(pop), .pc_load(pcld), .pc_load_value(pcv),
    .context_restore(restore), .restore_working(rw),
    .restore_status(rs), .restore_bank(rb), .restore_ptr0(rp0),
    .restore_ptr1(rp1), .restore_pc_latch(rpl));

  iecs_core_model i_core (.ref_clk(ref_clk), .reset(reset),
    .irq_request(irq_request), .arm(arm), .ret(ret), .lag(lag),
    .core_irq_accept(acc), .core_return_exec(rex), .core_pc(core_pc),
    .live_working(lw), .live_status(ls), .live_bank(lb), .live_ptr0(lp0),
    .live_ptr1(lp1), .live_pc_latch(lpl));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic await(ref int c, input int v);
    int j;
    for (j = 0; j < 80 && c != v; j++) @(posedge ref_clk);
    if (c != v) begin
      chk(c, v, "timeout");
      complete_run;
    end
  endtask

  // one clock at a time until hready is seen high mid-cycle, then on to the next rising edge
  task automatic ready_edge;
    int ok;
    ok = 0;
    for (int j = 0; j < 20 && ok == 0; j++) begin
      @(negedge ref_clk);
      ok = (hreadyout === 1'b1);
      @(posedge ref_clk);
    end
    if (ok == 0) begin
      chk(0, 1, "hready timeout");
      complete_run;
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, d,
                     output logic [7:0] r);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0000_00, a};
    ready_edge();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0000_00, d};
    // read data is taken at the edge that ends the data phase
    ready_edge();
    r = hrdata[7:0];
    chk({hresp, hrdata[31:8]}, 0, "okay and upper bits");
  endtask

  task automatic wr8(input logic [7:0] a, d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, exp, input string m);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, exp, m);
  endtask

  // irq_request is looked at mid-cycle, then the bench is back on an edge
  task automatic req_chk(input logic exp, input string m);
    @(negedge ref_clk);
    chk(irq_request, exp, m);
    @(posedge ref_clk);
  endtask

  task rst_chk;
    rdc(`IECS_ADDR_INTCTL, 8'h00, "ctl reset");
    rdc(`IECS_ADDR_PEN_ONE, 8'h00, "pen1 reset");
    rdc(`IECS_ADDR_PEN_TWO, 8'h00, "pen2 reset");
    req_chk(1'b0, "req reset");
  endtask

  // entry and return sequence watch, sampled mid-cycle
  always @(negedge ref_clk) begin
    if (aq2) chk({pcld, pcv}, {1'b1, `IECS_VECTOR}, "vector");
    if (aq1) chk({flush, push, irq_request, push_pc},
                 {3'b110, pc_q.pop_front()}, "entry");
    if (rq1) chk({pop, restore}, 2'b11, "return");
    aq2 = aq1;
    aq1 = acc & irq_request;
    rq1 = rex;
    if (acc & irq_request) begin
      pc_q.push_back(core_pc);
      cap = '{lw, ls & 8'hE7, {3'h0, lb}, lp0[7:0], lp0[15:8], lp1[7:0],
              lp1[15:8], {1'b0, lpl}};
      n_ent++;
    end
    if (rex) n_ret++;
  end

  initial begin
    {hsel, hwrite, edge_pin, edge_sel, t0_ovf, arm, ret} = 7'h00;
    {aq1, aq2, rq1, reset} = 4'h1;
    {haddr, hwdata} = 64'h0;
    {htrans, lag, pb, pf1, pf2} = 30'h0;
    hsize = 3'b010;
    {n_fail, n_compared, n_ent, n_ret} = 128'h0;
    void'($urandom(84));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rst_chk();
    wr8(8'h10, 8'hFF);
    rdc(8'h10, 8'h00, "unmapped");
    @(posedge ref_clk) t0_ovf <= 1'b1;
    @(posedge ref_clk) t0_ovf <= 1'b0;
    rdc(8'h00, 8'h04, "timer flag");
    req_chk(1'b0, "no enable");
    for (k = 0; k < 2; k++) begin
      wr8(8'h00, 8'h00);
      @(posedge ref_clk);
      edge_sel <= k[0];
      edge_pin <= ~k[0];
      repeat (6) @(posedge ref_clk);
      rdc(8'h00, 8'h00, "wrong edge");
      edge_pin <= k[0];
      repeat (6) @(posedge ref_clk);
      rdc(8'h00, 8'h02, "edge flag");
    end
    wr8(8'h00, 8'h00);
    @(posedge ref_clk) pb <= 8'h28;
    rdc(8'h00, 8'h01, "summary set");
    wr8(8'h00, 8'h00);
    pb <= 8'h08;
    rdc(8'h00, 8'h01, "summary held");
    pb <= 8'h00;
    wr8(8'h00, 8'h01);
    rdc(8'h00, 8'h00, "summary clear");
    for (k = 0; k < 24; k++) begin
      {w, p1, p2} = 24'($urandom);
      @(posedge ref_clk);
      pb  <= 8'($urandom & $urandom & $urandom);
      pf1 <= 8'($urandom & $urandom);
      pf2 <= 8'($urandom & $urandom);
      wr8(8'h00, w);
      wr8(8'h04, p1);
      wr8(8'h08, p2);
      e = {w[7:1], |pb};
      rdc(8'h00, e, "ctl rw");
      rdc(8'h04, p1, "pen1 rw");
      rdc(8'h08, p2 & 8'h89, "pen2 rw");
      req_chk(e[7] & ((|(e[5:3] & e[2:0])) | e[6] &
          ((|(p1 & pf1)) | (|(p2 & 8'h89 & pf2)))), "gating");
    end
    {pb, pf1, pf2} <= 24'h0;
    wr8(8'h04, 8'h00);
    wr8(8'h08, 8'h00);
    for (k = 0; k < 2; k++) begin
      wr8(8'h00, 8'h00);
      wr8(8'h00, 8'h20);
      @(posedge ref_clk) t0_ovf <= 1'b1;
      lag <= 4'(k * 5);
      arm <= 1'b1;
      @(posedge ref_clk) t0_ovf <= 1'b0;
      rdc(8'h00, 8'h24, "pending");
      req_chk(1'b0, "gate off");
      wr8(8'h00, 8'hA4);
      await(n_ent, k + 1);
      rdc(8'h00, 8'h24, "gate cleared");
      for (i = 0; i < 8; i++) rdc(8'(8'h40 + 4 * i), cap[i], "shadow");
      w = 8'($urandom);
      wr8(8'h40, w);
      rdc(8'h40, w, "shadow write");
      wr8(8'h00, 8'h20);
      @(posedge ref_clk);
      arm <= 1'b0;
      ret <= 1'b1;
      await(n_ret, k + 1);
      ret <= 1'b0;
      rdc(8'h00, 8'hA0, "gate set");
      chk({rw, rs, rb, rp0, rp1, rpl}, {w, cap[1], cap[2][4:0], cap[4],
          cap[3], cap[6], cap[5], cap[7][6:0]}, "restore");
    end
    wr8(8'h00, 8'hFE);
    wr8(8'h04, 8'hFF);
    wr8(8'h08, 8'hFF);
    req_chk(1'b1, "req on");
    rdc(`IECS_ADDR_STATE, 8'h08, "state reg");
    @(posedge ref_clk) reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rst_chk();
    complete_run;
  end
endmodule // iecs_irq_ctrl_tb
